// ===== addr_map_pkg.sv
/*
  Shared constants and types for the system address decoder: master numbering,
  the byte map of program/data space, external chip-select regions, I/O window
  lookup, target and peripheral encodings, and the request/route carriers.
  Assumes a 24-bit byte address for memory space and a 16-bit word address for I/O.
*/
`default_nettype none

package addr_map_pkg;

  // Master numbering
  localparam int NUM_MASTERS = 7;
  localparam int M_CPU = 0;
  localparam int M_DMA_FIRST = 1;
  localparam int M_DMA_LAST = 4;
  localparam int M_LCD = 5;
  localparam int M_USB = 6;

  // Program/data space byte map
  localparam logic [23:0] MMR_LIMIT = 24'h00_00C0;
  localparam logic [23:0] DUAL_ACCESS_RAM_LAST = 24'h00_FFFF;
  localparam logic [23:0] SINGLE_ACCESS_RAM_LAST = 24'h04_FFFF;
  localparam logic [23:0] EXT_BASE = 24'h05_0000;
  localparam logic [23:0] ROM_BASE = 24'hFE_0000;

  // External chip-select region bases; CS0 space starts at EXT_BASE
  localparam logic [23:0] CS2_BASE = 24'h40_0000;
  localparam logic [23:0] CS3_BASE = 24'h80_0000;
  localparam logic [23:0] CS4_BASE = 24'hC0_0000;
  localparam logic [23:0] CS5_BASE = 24'hE0_0000;

  // Block field positions and sizes
  localparam int DUAL_ACCESS_RAM_BLK_LSB = 13;
  localparam int SINGLE_ACCESS_RAM_BLK_LSB = 13;
  localparam logic [5:0] SINGLE_ACCESS_RAM_BLK_OFFSET = 6'h08;
  localparam int ROM_BLK_LSB = 15;
  localparam int DUAL_ACCESS_RAM_BLOCKS = 8;
  localparam int SINGLE_ACCESS_RAM_BLOCKS = 32;
  localparam int ROM_BLOCKS = 4;
  localparam logic [1:0] DUAL_ACCESS_RAM_PORTS = 2'h2;
  localparam int NUM_CS = 6;
  localparam int EXT_ADDR_W = 21;

  // Reset values
  localparam logic ROM_UNMAP_RESET = 1'b0;
  localparam logic [5:0] CS_IDLE = 6'h3F;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_MMR = 3'b001,
    TGT_DUAL_ACCESS_RAM = 3'b010,
    TGT_SINGLE_ACCESS_RAM = 3'b011,
    TGT_ROM = 3'b100,
    TGT_EXT = 3'b101,
    TGT_IO = 3'b110
  } target_t;

  typedef enum logic [4:0] {
    P_RSVD = 5'b00000, P_IDLE = 5'b00001, P_DMA0 = 5'b00010, P_DMA1 = 5'b00011,
    P_DMA2 = 5'b00100, P_DMA3 = 5'b00101, P_EXTMEM = 5'b00110, P_TIMER0 = 5'b00111,
    P_TIMER1 = 5'b01000, P_TIMER2 = 5'b01001, P_RTC = 5'b01010, P_I2C = 5'b01011,
    P_UART = 5'b01100, P_SYSCTL = 5'b01101, P_I2S0 = 5'b01110, P_I2S1 = 5'b01111,
    P_I2S2 = 5'b10000, P_I2S3 = 5'b10001, P_LCD = 5'b10010, P_SPI = 5'b10011,
    P_MMC0 = 5'b10100, P_MMC1 = 5'b10101, P_SAR = 5'b10110, P_USB = 5'b10111
  } periph_t;

  // One access request from a master
  typedef struct packed {
    logic valid;
    logic io;
    logic write;
    logic prog;
    logic [23:0] addr;
  } req_t;

  // Decoded destination of an access
  typedef struct packed {
    target_t tgt;
    periph_t periph;
    logic [4:0] blk;
    logic [23:0] addr;
  } route_t;

  // I/O word-address windows; anything not listed is reserved
  function automatic periph_t io_lookup(input logic [15:0] a);
    periph_t p;
    p = P_RSVD;
    if (a <= 16'h0004) p = P_IDLE;
    else if (a >= 16'h0C00 && a <= 16'h0C7F) p = P_DMA0;
    else if (a >= 16'h0D00 && a <= 16'h0D7F) p = P_DMA1;
    else if (a >= 16'h0E00 && a <= 16'h0E7F) p = P_DMA2;
    else if (a >= 16'h0F00 && a <= 16'h0F7F) p = P_DMA3;
    else if (a >= 16'h1000 && a <= 16'h10DD) p = P_EXTMEM;
    else if (a >= 16'h1800 && a <= 16'h181F) p = P_TIMER0;
    else if (a >= 16'h1840 && a <= 16'h185F) p = P_TIMER1;
    else if (a >= 16'h1880 && a <= 16'h189F) p = P_TIMER2;
    else if (a >= 16'h1900 && a <= 16'h197F) p = P_RTC;
    else if (a >= 16'h1A00 && a <= 16'h1A6C) p = P_I2C;
    else if (a >= 16'h1B00 && a <= 16'h1B1F) p = P_UART;
    else if (a >= 16'h1C00 && a <= 16'h1CFF) p = P_SYSCTL;
    else if (a >= 16'h2800 && a <= 16'h2840) p = P_I2S0;
    else if (a >= 16'h2900 && a <= 16'h2940) p = P_I2S1;
    else if (a >= 16'h2A00 && a <= 16'h2A40) p = P_I2S2;
    else if (a >= 16'h2B00 && a <= 16'h2B40) p = P_I2S3;
    else if (a >= 16'h2E00 && a <= 16'h2E40) p = P_LCD;
    else if (a >= 16'h3000 && a <= 16'h300F) p = P_SPI;
    else if (a >= 16'h3A00 && a <= 16'h3A7F) p = P_MMC0;
    else if (a >= 16'h3B00 && a <= 16'h3B7F) p = P_MMC1;
    else if (a >= 16'h7000 && a <= 16'h70FF) p = P_SAR;
    else if (a >= 16'h8000) p = P_USB;
    return p;
  endfunction

  // Peripherals whose registers the DMA controllers may reach
  function automatic logic dma_reachable(input periph_t p);
    return (p == P_I2C) || (p == P_UART) || (p == P_I2S0) || (p == P_I2S1) ||
           (p == P_I2S2) || (p == P_I2S3) || (p == P_MMC0) || (p == P_MMC1) ||
           (p == P_EXTMEM) || (p == P_USB) || (p == P_SAR);
  endfunction

endpackage

`default_nettype wire

// ===== access_decode.sv
/*
  Combinational decoder for one master's request: resolves memory or I/O space
  into a target, block index and peripheral code, honouring master permissions
  and the ROM-unmap state. Assumes the caller registers the result.
*/
`default_nettype none

module access_decode (
  // Request
  input wire addr_map_pkg::req_t req,
  // Master class
  input wire logic is_cpu,
  input wire logic is_dma,
  // Map state
  input wire logic rom_unmap,
  // Result
  output addr_map_pkg::route_t route
);

  // Block index fields: eight dual blocks, thirty-two single blocks, four ROM blocks
  localparam int SINGLE_ACCESS_RAM_IDX_HI = addr_map_pkg::SINGLE_ACCESS_RAM_BLK_LSB + 5;
  localparam int DUAL_ACCESS_RAM_IDX_HI = addr_map_pkg::DUAL_ACCESS_RAM_BLK_LSB + 2;
  localparam int ROM_IDX_HI = addr_map_pkg::ROM_BLK_LSB + 1;

  logic [5:0] single_access_ram_idx;

  // Space decode in priority order; a TGT_NONE result completes with zeros
  always_comb begin
    single_access_ram_idx = req.addr[SINGLE_ACCESS_RAM_IDX_HI:addr_map_pkg::SINGLE_ACCESS_RAM_BLK_LSB] -
                addr_map_pkg::SINGLE_ACCESS_RAM_BLK_OFFSET;
    route = '0;
    route.tgt = addr_map_pkg::TGT_NONE;
    route.periph = addr_map_pkg::P_RSVD;
    route.addr = req.addr;
    if (req.io) begin
      // Only CPU and DMA reach I/O space
      if (is_cpu || is_dma) begin
        route.periph = addr_map_pkg::io_lookup(req.addr[15:0]);
        if (route.periph != addr_map_pkg::P_RSVD &&
            (is_cpu || addr_map_pkg::dma_reachable(route.periph))) begin
          route.tgt = addr_map_pkg::TGT_IO;
        end
      end
    end else if (req.addr < addr_map_pkg::MMR_LIMIT) begin
      if (is_cpu) route.tgt = addr_map_pkg::TGT_MMR;
    end else if (req.addr <= addr_map_pkg::DUAL_ACCESS_RAM_LAST) begin
      // LCD and USB masters are kept out of dual-access RAM
      if (is_cpu || is_dma) begin
        route.tgt = addr_map_pkg::TGT_DUAL_ACCESS_RAM;
        route.blk = {2'b00, req.addr[DUAL_ACCESS_RAM_IDX_HI:addr_map_pkg::DUAL_ACCESS_RAM_BLK_LSB]};
      end
    end else if (req.addr <= addr_map_pkg::SINGLE_ACCESS_RAM_LAST) begin
      route.tgt = addr_map_pkg::TGT_SINGLE_ACCESS_RAM;
      route.blk = single_access_ram_idx[4:0];
    end else if (req.addr >= addr_map_pkg::ROM_BASE) begin
      // Top range is ROM only while mapped; otherwise unmapped
      if (!rom_unmap && is_cpu) begin
        route.tgt = addr_map_pkg::TGT_ROM;
        route.blk = {3'b000, req.addr[ROM_IDX_HI:addr_map_pkg::ROM_BLK_LSB]};
      end
    end else begin
      route.tgt = addr_map_pkg::TGT_EXT;
      // Chip-select region index in blk
      if (req.addr >= addr_map_pkg::CS5_BASE) route.blk = 5'h05;
      else if (req.addr >= addr_map_pkg::CS4_BASE) route.blk = 5'h04;
      else if (req.addr >= addr_map_pkg::CS3_BASE) route.blk = 5'h03;
      else if (req.addr >= addr_map_pkg::CS2_BASE) route.blk = 5'h02;
      else route.blk = 5'h00;
    end
  end

endmodule // access_decode

`default_nettype wire

// ===== system_address_decoder.sv
/*
  System address decoder: decodes and arbitrates the accesses of seven bus
  masters onto on-chip RAM, ROM, external chip-select spaces and I/O windows,
  drives the external chip selects and address, and holds the ROM-unmap bit.
  Assumes requests are synchronous to clk and held until acknowledged.
*/
`default_nettype none

// How it works
// - While ROM mapped, FE0000h to FFFFFFh goes to on-chip ROM.
// - Setting the unmap bit removes ROM; the top range reads as unmapped.
// - Hardware reset clears the unmap bit.
// - Software reset leaves the unmap bit untouched.
// - ROM is four 16K-word blocks, one access per block per cycle.
// - ROM reachable by CPU program fetches and data accesses.
// - 050000h to FDFFFFh decodes as external memory.
// - External space splits into five chip-select regions, SDRAM first.
// - Each external access drives its region's active-low chip select.
// - SDRAM region uses chip select zero alone or zero and one.
// - External address up to 21 bits; data bus 16 or 8 bits.
// - I/O space decoded apart, reached only by CPU I/O or DMA.
// - I/O word addresses select peripheral register windows.
// - DMA controllers reach I2C, UART, I2S, card, memory-if, USB, ADC.
// - Unmapped accesses complete with zero read data; writes dropped.
// - USB and LCD masters are kept out of dual-access RAM.
// - Accepts CPU, four DMA, LCD and USB core DMA masters.
// - Dual-access blocks take two accesses a cycle, single-access one.
// - Lowest 192 bytes decode to CPU mapped registers.
// - Dual-access RAM at 000000h to 00FFFFh, eight blocks.
// - Single-access RAM at 010000h to 04FFFFh, thirty-two blocks.
module system_address_decoder #(
  parameter int N = addr_map_pkg::NUM_MASTERS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Map control
  input wire logic rom_unmap_wr,
  input wire logic rom_unmap_wdata,
  input wire logic soft_reset,
  input wire logic sdram_two_cs,
  input wire logic ext_bus_8bit,
  // Master requests
  input wire addr_map_pkg::req_t [N-1:0] req,
  // Master answers
  output logic [N-1:0] ack,
  output logic [N-1:0] zero_data,
  output addr_map_pkg::route_t [N-1:0] route,
  // External memory pins
  output logic [addr_map_pkg::NUM_CS-1:0] ext_chip_select_n,
  output logic [addr_map_pkg::EXT_ADDR_W-1:0] ext_addr,
  output logic ext_write,
  // Status
  output logic rom_unmap_bit
);

  localparam int RRW = $clog2(N);

  typedef struct packed {
    logic rom_unmap;
    logic [N-1:0] ack;
    logic [N-1:0] zero;
    addr_map_pkg::route_t [N-1:0] route;
    logic [addr_map_pkg::NUM_CS-1:0] cs_n;
    logic [addr_map_pkg::EXT_ADDR_W-1:0] ext_addr;
    logic ext_write;
    logic [RRW-1:0] rr;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic rst_meta_q;
  logic rst_sync_q;
  addr_map_pkg::route_t [N-1:0] dec;

  // Reset release through two flops; the first is read only by the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // One decoder per master; class follows the master numbering
  for (genvar g = 0; g < N; g++) begin : g_dec
    access_decode u_dec (
      .req(req[g]),
      .is_cpu(g == addr_map_pkg::M_CPU),
      .is_dma(g >= addr_map_pkg::M_DMA_FIRST && g <= addr_map_pkg::M_DMA_LAST),
      .rom_unmap(s_q.rom_unmap),
      .route(dec[g])
    );
  end

  // Rotating-priority arbitration per block and per shared target.
  // Rotation keeps a busy DMA from starving the others, at the cost of
  // giving no master a fixed latency bound tighter than N cycles.
  always_comb begin
    logic [1:0] dual_access_ram_use [addr_map_pkg::DUAL_ACCESS_RAM_BLOCKS];
    logic [addr_map_pkg::SINGLE_ACCESS_RAM_BLOCKS-1:0] single_access_ram_use;
    logic [addr_map_pkg::ROM_BLOCKS-1:0] rom_use;
    logic ext_use;
    logic io_use;
    logic mmr_use;
    logic grant;
    int m;
    for (int b = 0; b < addr_map_pkg::DUAL_ACCESS_RAM_BLOCKS; b++) dual_access_ram_use[b] = 2'h0;
    single_access_ram_use = '0;
    rom_use = '0;
    ext_use = 1'b0;
    io_use = 1'b0;
    mmr_use = 1'b0;
    grant = 1'b0;
    m = 0;
    s_d = s_q;
    s_d.ack = '0;
    s_d.zero = '0;
    s_d.cs_n = addr_map_pkg::CS_IDLE;
    s_d.ext_write = 1'b0;
    // Unmap bit follows software writes; soft reset has no say here
    if (rom_unmap_wr) s_d.rom_unmap = rom_unmap_wdata;
    for (int k = 0; k < N; k++) begin
      m = int'(s_q.rr) + k;
      if (m >= N) m = m - N;
      grant = 1'b0;
      if (req[m].valid && !s_q.ack[m]) begin
        unique case (dec[m].tgt)
          addr_map_pkg::TGT_NONE: begin
            grant = 1'b1;
            s_d.zero[m] = 1'b1;
          end
          addr_map_pkg::TGT_MMR: begin
            grant = !mmr_use;
            mmr_use = 1'b1;
          end
          addr_map_pkg::TGT_DUAL_ACCESS_RAM: begin
            // Two ports per dual-access block
            if (dual_access_ram_use[dec[m].blk[2:0]] < addr_map_pkg::DUAL_ACCESS_RAM_PORTS) begin
              grant = 1'b1;
              dual_access_ram_use[dec[m].blk[2:0]] = dual_access_ram_use[dec[m].blk[2:0]] + 2'h1;
            end
          end
          addr_map_pkg::TGT_SINGLE_ACCESS_RAM: begin
            // One access per single-access block; losers stall
            grant = !single_access_ram_use[dec[m].blk];
            single_access_ram_use[dec[m].blk] = 1'b1;
          end
          addr_map_pkg::TGT_ROM: begin
            grant = !rom_use[dec[m].blk[1:0]];
            rom_use[dec[m].blk[1:0]] = 1'b1;
          end
          addr_map_pkg::TGT_EXT: begin
            // One memory interface: a single external access per cycle
            if (!ext_use) begin
              grant = 1'b1;
              ext_use = 1'b1;
              s_d.cs_n[dec[m].blk[2:0]] = 1'b0;
              if (dec[m].blk == 5'h00 && sdram_two_cs) s_d.cs_n[1] = 1'b0;
              s_d.ext_write = req[m].write;
              // Byte address in 8-bit mode, word address in 16-bit mode
              s_d.ext_addr = ext_bus_8bit ? req[m].addr[addr_map_pkg::EXT_ADDR_W-1:0]
                                          : req[m].addr[addr_map_pkg::EXT_ADDR_W:1];
            end
          end
          addr_map_pkg::TGT_IO: begin
            grant = !io_use;
            io_use = 1'b1;
          end
          default: grant = 1'b1;
        endcase
      end
      if (grant) begin
        s_d.ack[m] = 1'b1;
        s_d.route[m] = dec[m];
      end
    end
    // Advance the rotation every active cycle
    if (s_q.rr == RRW'(N - 1)) s_d.rr = '0;
    else s_d.rr = s_q.rr + RRW'(1);
  end

  // State register; ce freezes everything
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
      s_q.rom_unmap <= addr_map_pkg::ROM_UNMAP_RESET;
      s_q.cs_n <= addr_map_pkg::CS_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign ack = s_q.ack;
  assign zero_data = s_q.zero;
  assign route = s_q.route;
  assign ext_chip_select_n = s_q.cs_n;
  assign ext_addr = s_q.ext_addr;
  assign ext_write = s_q.ext_write;
  assign rom_unmap_bit = s_q.rom_unmap;

endmodule // system_address_decoder

`default_nettype wire

// ===== master_model.sv
/*
  Bus master model: holds one request whole until the decoder acknowledges it.
  Assumes the bench loads a command with a one-cycle start pulse.
*/
`default_nettype none

module master_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Command from the bench
  input wire logic start,
  input wire addr_map_pkg::req_t cmd,
  // Handshake
  input wire logic ack,
  output var addr_map_pkg::req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench keeps to listed windows and to set-up order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req <= '0;
    end else if (start) begin
      req <= cmd;
    end else if (req.valid && ack) begin
      req <= {1'b0, ~req[26:0]}; // Released fields flip so stale values cannot match
    end
  end
endmodule // master_model

`default_nettype wire

// ===== system_address_decoder_sva.sv
/*
  Checker for the system address decoder: chip selects, acks, zero flags, unmap bit.
  Assumes a bind onto the top module; sees only its ports.
*/
`default_nettype none

module system_address_decoder_chk #(
  parameter int N = addr_map_pkg::NUM_MASTERS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic rom_unmap_wr,
  input wire logic rom_unmap_wdata,
  input wire logic [N-1:0] ack,
  input wire logic [N-1:0] zero_data,
  input wire addr_map_pkg::route_t [N-1:0] route,
  input wire logic [addr_map_pkg::NUM_CS-1:0] ext_chip_select_n,
  input wire logic ext_write,
  input wire logic rom_unmap_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Internal reset lags the pin, so writes count only once this saturates
  logic [1:0] up_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  sequence s_wr;
    up_q == 2'h3 && ce && rom_unmap_wr;
  endsequence
  sequence s_idle;
    up_q == 2'h3 && !(ce && rom_unmap_wr);
  endsequence
  property p_unmap_load;
    s_wr |=> rom_unmap_bit == $past(rom_unmap_wdata);
  endproperty
  property p_unmap_keep;
    s_idle |=> $stable(rom_unmap_bit);
  endproperty
  property p_cs_ack;
    ext_chip_select_n != addr_map_pkg::CS_IDLE |-> ack != '0;
  endproperty
  property p_cs_legal;
    ext_chip_select_n inside {6'h3E, 6'h3C, 6'h3B, 6'h37, 6'h2F, 6'h1F, 6'h3F};
  endproperty
  property p_cs1_pair;
    !ext_chip_select_n[1] |-> !ext_chip_select_n[0];
  endproperty
  property p_zero_ack;
    (zero_data & ~ack) == '0;
  endproperty
  property p_no_regrant;
    // A frozen clock enable holds ack, so only running cycles count
    ack != '0 && ce |=> (ack & $past(ack)) == '0;
  endproperty
  property p_wr_cs;
    ext_write |-> ext_chip_select_n != addr_map_pkg::CS_IDLE;
  endproperty
  property p_rom_mapped;
    $rose(ack[0]) && route[0].tgt == addr_map_pkg::TGT_ROM |-> !$past(rom_unmap_bit);
  endproperty
  property p_no_dual;
    !((ack[5] && route[5].tgt == addr_map_pkg::TGT_DUAL_ACCESS_RAM) ||
      (ack[6] && route[6].tgt == addr_map_pkg::TGT_DUAL_ACCESS_RAM));
  endproperty
  a_unmap_load: assert property (p_unmap_load)
    else $error("unmap bit did not load");
  a_unmap_keep: assert property (p_unmap_keep)
    else $error("unmap bit changed without write");
  a_cs_ack: assert property (p_cs_ack)
    else $error("chip select without ack");
  a_cs_legal: assert property (p_cs_legal)
    else $error("illegal chip select pattern");
  a_cs1_pair: assert property (p_cs1_pair)
    else $error("second sdram select alone");
  a_zero_ack: assert property (p_zero_ack)
    else $error("zero flag without ack");
  a_no_regrant: assert property (p_no_regrant)
    else $error("master acked twice in a row");
  a_wr_cs: assert property (p_wr_cs)
    else $error("external write without select");
  a_rom_mapped: assert property (p_rom_mapped)
    else $error("rom reached while unmapped");
  a_no_dual: assert property (p_no_dual)
    else $error("lcd or usb reached dual ram");
endmodule // system_address_decoder_chk

`default_nettype wire

// ===== test_system_address_decoder.sv
/*
  Testbench for the system address decoder: map, unmap, external, permissions, conflicts.
  Assumes master_model drives every request port and the checker is bound below.
*/
`default_nettype none

module test_system_address_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = addr_map_pkg::NUM_MASTERS;
  logic clk;
  logic rst_b;
  logic ce;
  logic rom_unmap_wr;
  logic rom_unmap_wdata;
  logic soft_reset;
  logic sdram_two_cs;
  logic ext_bus_8bit;
  logic [N-1:0] start;
  addr_map_pkg::req_t [N-1:0] cmd;
  addr_map_pkg::req_t [N-1:0] req;
  logic [N-1:0] ack;
  logic [N-1:0] zero_data;
  addr_map_pkg::route_t [N-1:0] route;
  logic [5:0] cs_n;
  logic [20:0] ext_addr;
  logic ext_write;
  logic unmap;
  int miscompares;
  int check_count;

  system_address_decoder #(.N(N)) i_system_address_decoder (
    .clk(clk), .rst_b(rst_b), .ce(ce), .rom_unmap_wr(rom_unmap_wr),
    .rom_unmap_wdata(rom_unmap_wdata), .soft_reset(soft_reset), .sdram_two_cs(sdram_two_cs),
    .ext_bus_8bit(ext_bus_8bit), .req(req), .ack(ack), .zero_data(zero_data),
    .route(route), .ext_chip_select_n(cs_n), .ext_addr(ext_addr), .ext_write(ext_write),
    .rom_unmap_bit(unmap));

  // One model per master
  for (genvar g = 0; g < N; g++) begin : g_m
    master_model i_master_model (.clk(clk), .rst_b(rst_b), .start(start[g]),
      .cmd(cmd[g]), .ack(ack[g]), .req(req[g]));
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write and fetch flavours follow address bits 13 and 15; the MMR and ROM accesses here are never writes
  task automatic acc(input int m, input logic io, input logic [23:0] a,
                     input addr_map_pkg::target_t t, input logic [4:0] b, input logic [5:0] c);
    int n;
    @(posedge clk);
    cmd[m] <= '{valid: 1'b1, io: io, write: a[13], prog: a[15], addr: a};
    start[m] <= 1'b1;
    @(posedge clk);
    start[m] <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ack[m] !== 1'b1 && n < 20);
    cmp(24'(ack[m]), 24'h00_0001);
    cmp(24'(route[m].tgt), 24'(t));
    cmp(24'(zero_data[m]), 24'(t == addr_map_pkg::TGT_NONE));
    cmp(24'(cs_n), 24'(c));
    if (t inside {addr_map_pkg::TGT_DUAL_ACCESS_RAM, addr_map_pkg::TGT_SINGLE_ACCESS_RAM, addr_map_pkg::TGT_ROM})
      cmp(24'(route[m].blk), 24'(b));
  endtask

  task automatic set_unmap(input logic v);
    @(posedge clk);
    rom_unmap_wr <= 1'b1;
    rom_unmap_wdata <= v;
    @(posedge clk);
    rom_unmap_wr <= 1'b0;
    #1 cmp(24'(unmap), 24'(v));
  endtask

  task automatic t_map();
    logic [23:0] a [12] = '{24'h00_0000, 24'h00_00C0, 24'h00_E000, 24'h01_0000,
      24'h04_E000, 24'h05_0000, 24'h40_0000, 24'h80_0000, 24'hC0_0000, 24'hE0_0000,
      24'hFE_0000, 24'hFF_8000};
    logic [4:0] b [12] = '{0, 0, 7, 0, 31, 0, 0, 0, 0, 0, 0, 3};
    logic [5:0] c [12] = '{6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h3E, 6'h3B, 6'h37, 6'h2F,
      6'h1F, 6'h3F, 6'h3F};
    addr_map_pkg::target_t t [12] = '{addr_map_pkg::TGT_MMR, addr_map_pkg::TGT_DUAL_ACCESS_RAM,
      addr_map_pkg::TGT_DUAL_ACCESS_RAM, addr_map_pkg::TGT_SINGLE_ACCESS_RAM, addr_map_pkg::TGT_SINGLE_ACCESS_RAM,
      addr_map_pkg::TGT_EXT, addr_map_pkg::TGT_EXT, addr_map_pkg::TGT_EXT,
      addr_map_pkg::TGT_EXT, addr_map_pkg::TGT_EXT, addr_map_pkg::TGT_ROM,
      addr_map_pkg::TGT_ROM};
    for (int i = 0; i < 12; i++)
      acc(0, 1'b0, a[i], t[i], b[i], c[i]);
  endtask

  task automatic t_unmap();
    set_unmap(1'b1);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    #1 cmp(24'(unmap), 24'h00_0001);
    acc(0, 1'b0, 24'hFE_0000, addr_map_pkg::TGT_NONE, 5'h00, 6'h3F);
    set_unmap(1'b0);
    acc(0, 1'b0, 24'hFF_8000, addr_map_pkg::TGT_ROM, 5'h03, 6'h3F);
  endtask

  task automatic t_ext();
    @(posedge clk);
    sdram_two_cs <= 1'b1;
    acc(2, 1'b0, 24'h05_2000, addr_map_pkg::TGT_EXT, 5'h00, 6'h3C);
    cmp(24'(ext_write), 24'h00_0001);
    cmp(24'(ext_addr), 24'h02_9000);
    @(posedge clk);
    sdram_two_cs <= 1'b0;
    ext_bus_8bit <= 1'b1;
    acc(3, 1'b0, 24'h1F_FFFE, addr_map_pkg::TGT_EXT, 5'h00, 6'h3E);
    cmp(24'(ext_addr), 24'h1F_FFFE);
  endtask

  // Clock enable low: a write held during the freeze must not be taken
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    rom_unmap_wr <= 1'b1;
    rom_unmap_wdata <= 1'b1;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rom_unmap_wr <= 1'b0;
    #1 cmp(24'(unmap), 24'(addr_map_pkg::ROM_UNMAP_RESET));
  endtask

  task automatic t_perm();
    int m [9] = '{0, 0, 0, 1, 1, 3, 5, 5, 6};
    logic [15:0] a [9] = '{16'h8000, 16'h0C00, 16'h0005, 16'h1A00, 16'h0000, 16'h7000,
      16'h2E00, 16'h2000, 16'h2000};
    logic [0:8] io = 9'b1_1111_1100;
    addr_map_pkg::periph_t p [9] = '{addr_map_pkg::P_USB, addr_map_pkg::P_DMA0,
      addr_map_pkg::P_RSVD, addr_map_pkg::P_I2C, addr_map_pkg::P_RSVD, addr_map_pkg::P_SAR,
      addr_map_pkg::P_RSVD, addr_map_pkg::P_RSVD, addr_map_pkg::P_RSVD};
    addr_map_pkg::target_t t;
    for (int i = 0; i < 9; i++) begin
      t = (p[i] == addr_map_pkg::P_RSVD) ? addr_map_pkg::TGT_NONE : addr_map_pkg::TGT_IO;
      acc(m[i], io[i], {8'h00, a[i]}, t, 5'h00, 6'h3F);
      if (io[i] && t == addr_map_pkg::TGT_IO) cmp(24'(route[m[i]].periph), 24'(p[i]));
    end
    acc(6, 1'b0, 24'h01_2000, addr_map_pkg::TGT_SINGLE_ACCESS_RAM, 5'h01, 6'h3F);
  endtask

  // Two masters on one block at once; dual ram takes both in one cycle
  task automatic pair(input logic [23:0] a, input logic same);
    int t0;
    int t1;
    t0 = 0;
    t1 = 0;
    @(posedge clk);
    cmd[0] <= '{valid: 1'b1, io: 1'b0, write: 1'b0, prog: 1'b0, addr: a};
    cmd[1] <= '{valid: 1'b1, io: 1'b0, write: 1'b1, prog: 1'b0, addr: a};
    start <= 7'h03;
    @(posedge clk);
    start <= 7'h00;
    for (int n = 1; n < 12; n++) begin
      @(posedge clk);
      #1;
      if (ack[0] === 1'b1) t0 = n;
      if (ack[1] === 1'b1) t1 = n;
    end
    cmp(24'(t0 != 0 && t1 != 0), 24'h00_0001);
    cmp(24'(t0 == t1), 24'(same));
  endtask

  task automatic t_reset();
    set_unmap(1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp(24'(unmap), 24'(addr_map_pkg::ROM_UNMAP_RESET));
    cmp(24'(cs_n), 24'(addr_map_pkg::CS_IDLE));
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, 1'b0, 24'hFE_0000, addr_map_pkg::TGT_ROM, 5'h00, 6'h3F);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: far beyond the roughly 150 cycles the tests take
  initial begin
    #200_000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    rom_unmap_wr = 1'b0;
    rom_unmap_wdata = 1'b0;
    soft_reset = 1'b0;
    sdram_two_cs = 1'b0;
    ext_bus_8bit = 1'b0;
    start = '0;
    cmd = '0;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp(24'(unmap), 24'(addr_map_pkg::ROM_UNMAP_RESET));
    t_map();
    t_unmap();
    t_ext();
    t_freeze();
    t_perm();
    pair(24'h01_0000, 1'b0);
    pair(24'h00_2000, 1'b1);
    t_reset();
    tally_and_finish();
  end
endmodule // test_system_address_decoder

bind system_address_decoder system_address_decoder_chk #(.N(N)) i_system_address_decoder_chk (
  .clk(clk), .rst_b(rst_b), .ce(ce), .rom_unmap_wr(rom_unmap_wr),
  .rom_unmap_wdata(rom_unmap_wdata), .ack(ack), .zero_data(zero_data), .route(route),
  .ext_chip_select_n(ext_chip_select_n), .ext_write(ext_write), .rom_unmap_bit(rom_unmap_bit));

`default_nettype wire
